// >>> shared/ampc_defs.svh
`ifndef AMPC_DEFS_SVH
`define AMPC_DEFS_SVH

`define AMPC_CLK_HZ        200000000
`define AMPC_START_DLY_US  16400
`define AMPC_START_DLY_CYC ((`AMPC_START_DLY_US * (`AMPC_CLK_HZ / 1000000)))
`define AMPC_OSC_DIV       400
`define AMPC_SYNC_STAGES   2

`define AMPC_REG_STATUS    8'h00
`define AMPC_REG_MASK      8'h04
`define AMPC_REG_STATE     8'h08
`define AMPC_STAT_SHORT    0
`define AMPC_STAT_THERM    1
`define AMPC_STAT_START    2
`define AMPC_STAT_W        3
`define AMPC_MASK_RST      3'h0

`endif

// >>> shared/ampc_pkg.sv
package ampc_pkg;
    typedef enum logic [1:0] {
        AMPC_OFF   = 2'b00,
        AMPC_BIAS  = 2'b01,
        AMPC_DELAY = 2'b10,
        AMPC_RUN   = 2'b11
    } ampc_state_t;
endpackage

// >>> src/ampc_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser per bit; first flop feeds only the second
module ampc_sync #(
    parameter int W = 1
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    // Metastability filter
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule
`default_nettype wire

// >>> src/ampc_osc.sv
`timescale 1ns/100ps
`default_nettype none
// Switching clock source: divider in master role, edge follower in slave role
module ampc_osc #(
    parameter int DIV = 400
) (
    input  wire logic i_ref_clk,
    input  wire logic i_nrst,
    input  wire logic i_master,
    input  wire logic i_run,
    input  wire logic i_sync_in,
    output logic      o_sw_clk,
    output logic      o_sw_tick
);
    localparam int HALF = DIV / 2;
    logic [15:0] cnt_r;
    logic        sync_d_r;

    // Half-period divider; stands still while not running to save current
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_r    <= 16'h0000;
            o_sw_clk <= 1'b0;
            sync_d_r <= 1'b0;
        end else begin
            sync_d_r <= i_sync_in;
            if (!i_master) begin
                cnt_r    <= 16'h0000;
                o_sw_clk <= i_sync_in;
            end else if (!i_run) begin
                cnt_r    <= 16'h0000;
                o_sw_clk <= 1'b0;
            end else if (cnt_r == 16'(HALF - 1)) begin
                cnt_r    <= 16'h0000;
                o_sw_clk <= ~o_sw_clk;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // One-cycle pulse on each rising switching edge
    assign o_sw_tick = i_master ? (o_sw_clk == 1'b0 && cnt_r == 16'(HALF - 1) && i_run)
                                : (i_sync_in && !sync_d_r);
endmodule
`default_nettype wire

// >>> src/ampc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ampc_defs.svh"
// Protection and switching control of a mono class-D output stage
module ampc_top #(
    parameter int START_DLY_CYC = `AMPC_START_DLY_CYC,
    parameter int OSC_DIV       = `AMPC_OSC_DIV
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_power_down_n,
    input  wire logic       i_output_silence,
    input  wire logic       i_short_det,
    input  wire logic       i_over_temp,
    input  wire logic       i_therm_clear,
    input  wire logic       i_bias_ok,
    input  wire logic       i_clock_role_select,
    input  wire logic       i_sync_in,
    output logic            o_sync_out,
    output logic            o_sync_oe,
    output logic            o_short_alarm_out,
    output logic            o_out_enable,
    output logic            o_low_power,
    output logic            o_sw_tick,
    input  wire logic [7:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [31:0] o_rdata,
    output logic            o_irq
);
    logic [2:0]  fault_s;
    logic        short_s;
    logic        hot_s;
    logic        cool_s;
    logic        short_hit;
    logic        short_flag_r;
    logic        therm_flag_r;
    logic        pdn_d_r;
    logic        sil_d_r;
    logic        cycled;
    logic [31:0] dly_cnt_r;
    ampc_pkg::ampc_state_t state_r;
    ampc_pkg::ampc_state_t state_nxt;
    logic [`AMPC_STAT_W-1:0] stat_r;
    logic [`AMPC_STAT_W-1:0] mask_r;
    logic [`AMPC_STAT_W-1:0] evt;
    logic        sw_clk;
    logic        running;
    logic        start_evt;

    // Comparator inputs brought into the clock domain before use
    ampc_sync #(
        .W(3)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_async   ({i_therm_clear, i_over_temp, i_short_det}),
        .o_sync    (fault_s)
    );
    assign short_s = fault_s[0];
    assign hot_s   = fault_s[1];
    assign cool_s  = fault_s[2];

    // Edge memory of the control inputs for clear-by-cycling
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pdn_d_r <= 1'b1;
            sil_d_r <= 1'b0;
        end else begin
            pdn_d_r <= i_power_down_n;
            sil_d_r <= i_output_silence;
        end
    end
    // Rising silence or falling power-down counts as a cycle
    assign cycled = (i_output_silence && !sil_d_r) || (!i_power_down_n && pdn_d_r);
    // A silenced stage cannot show a short, so a silence rise always wins the clear
    assign short_hit = short_s && running && !i_output_silence;

    // Latched short fault; set wins over a same-cycle clear
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            short_flag_r <= 1'b0;
        end else if (short_hit) begin
            short_flag_r <= 1'b1;
        end else if (cycled) begin
            short_flag_r <= 1'b0;
        end
    end
    // Alarm mirrors the latched flag; looping it to silence self-clears
    assign o_short_alarm_out = short_flag_r;

    // Thermal fault is non-latched, with hysteresis from the comparator pair
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            therm_flag_r <= 1'b0;
        end else if (hot_s) begin
            therm_flag_r <= 1'b1;
        end else if (cool_s) begin
            therm_flag_r <= 1'b0;
        end
    end

    // Power sequence: off, wait for bias, fixed delay, run
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ampc_pkg::AMPC_OFF: begin
                if (i_power_down_n && !therm_flag_r) begin
                    state_nxt = ampc_pkg::AMPC_BIAS;
                end
            end
            ampc_pkg::AMPC_BIAS: begin
                if (i_bias_ok) begin
                    state_nxt = ampc_pkg::AMPC_DELAY;
                end
            end
            ampc_pkg::AMPC_DELAY: begin
                if (dly_cnt_r == 32'(START_DLY_CYC - 1)) begin
                    state_nxt = ampc_pkg::AMPC_RUN;
                end
            end
            ampc_pkg::AMPC_RUN: begin
                state_nxt = ampc_pkg::AMPC_RUN;
            end
            default: begin
                state_nxt = ampc_pkg::AMPC_OFF;
            end
        endcase
        // Shutdown by pin or heat overrides any step
        if (!i_power_down_n || therm_flag_r) begin
            state_nxt = ampc_pkg::AMPC_OFF;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= ampc_pkg::AMPC_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Start-up delay counter, restarted on every entry to the delay step
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dly_cnt_r <= 32'h0000_0000;
        end else if (state_r == ampc_pkg::AMPC_DELAY) begin
            dly_cnt_r <= dly_cnt_r + 32'h0000_0001;
        end else begin
            dly_cnt_r <= 32'h0000_0000;
        end
    end

    assign running     = (state_r == ampc_pkg::AMPC_RUN);
    assign o_low_power = (state_r == ampc_pkg::AMPC_OFF);
    // Drive gated combinationally by the synchronised short, so it drops a cycle before the latched flag
    assign o_out_enable = running && !i_output_silence && !short_flag_r
                          && !short_s && !therm_flag_r;

    ampc_osc #(
        .DIV(OSC_DIV)
    ) u_osc (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_master  (i_clock_role_select),
        .i_run     (!o_low_power),
        .i_sync_in (i_sync_in),
        .o_sw_clk  (sw_clk),
        .o_sw_tick (o_sw_tick)
    );
    // Master drives the sync pin push-pull; slave releases it
    assign o_sync_out = i_clock_role_select ? sw_clk : 1'b0;
    assign o_sync_oe  = i_clock_role_select;

    // Sticky events for software
    assign start_evt = (state_r == ampc_pkg::AMPC_DELAY) && (state_nxt == ampc_pkg::AMPC_RUN);
    assign evt[`AMPC_STAT_SHORT] = short_hit && !short_flag_r;
    assign evt[`AMPC_STAT_THERM] = hot_s && !therm_flag_r;
    assign evt[`AMPC_STAT_START] = start_evt;

    // Write-one-to-clear status; a new event beats the clear
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stat_r <= '0;
        end else if (i_wr && i_addr == `AMPC_REG_STATUS) begin
            stat_r <= (stat_r & ~i_wdata[`AMPC_STAT_W-1:0]) | evt;
        end else begin
            stat_r <= stat_r | evt;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mask_r <= `AMPC_MASK_RST;
        end else if (i_wr && i_addr == `AMPC_REG_MASK) begin
            mask_r <= i_wdata[`AMPC_STAT_W-1:0];
        end
    end

    // Read data registered, valid only the cycle after the strobe
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                `AMPC_REG_STATUS: o_rdata <= {29'h0, stat_r};
                `AMPC_REG_MASK:   o_rdata <= {29'h0, mask_r};
                `AMPC_REG_STATE:  o_rdata <= {27'h0, therm_flag_r, short_flag_r, o_out_enable, state_r};
                default:          o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    assign o_irq = |(stat_r & mask_r);

    // Latched short holds the drive off until a cycle of the control pins
    a_short_latch: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        short_flag_r && !cycled |=> short_flag_r && !o_out_enable)
        else $error("short fault dropped without a cycle");
    // A silence rise or power-down fall clears the flag next cycle unless a short hit comes in the same cycle
    a_cycle_clear: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        short_flag_r && cycled && !short_hit |=> !o_short_alarm_out)
        else $error("fault not cleared by cycling");
    // Silence disables the stage at once
    a_silence_off: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_output_silence |-> !o_out_enable)
        else $error("output enabled while silenced");
    // Power-down gives low power within one cycle
    a_pdn_low: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !i_power_down_n |=> o_low_power && !o_out_enable)
        else $error("power-down not honoured");
    // Heat forces shutdown the cycle after the flag
    a_therm_shut: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        therm_flag_r |=> o_low_power)
        else $error("thermal fault without shutdown");
    // Thermal flag falls after clear with no heat and no other action
    a_therm_clear: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        therm_flag_r && !hot_s && cool_s |=> !therm_flag_r)
        else $error("thermal fault did not clear");
    // Run begins only after the full delay count
    a_start_delay: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        $rose(running) |-> $past(dly_cnt_r) == 32'(START_DLY_CYC - 1))
        else $error("switching began before the delay");
    // Master drives the pin with the divider clock; slave never drives
    a_sync_role: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_sync_oe == i_clock_role_select && (!i_clock_role_select || o_sync_out == sw_clk))
        else $error("sync pin role wrong");
    // Slave follows the incoming wave one cycle later
    a_slave_follow: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !i_clock_role_select ##1 !i_clock_role_select |-> sw_clk == $past(i_sync_in))
        else $error("slave clock not following sync");
endmodule
`default_nettype wire

// >>> tb/ampc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host GPIO pins plus a peer amplifier that sources the sync square wave
module ampc_host_model #(
    parameter int SYNC_HALF = 12
) (
    input  wire logic i_ref_clk,
    input  wire logic i_host_pd_n,
    input  wire logic i_host_silence,
    input  wire logic i_loop_en,
    input  wire logic i_alarm,
    input  wire logic i_sync_run,
    output logic      o_power_down_n,
    output logic      o_output_silence,
    output logic      o_sync
);
    int cnt = 0;

    // Control pins are always driven to a defined level, never left floating
    assign o_power_down_n   = i_host_pd_n;
    // Alarm ORed with the host request gives automatic recovery
    assign o_output_silence = i_host_silence | (i_loop_en & i_alarm);

    // Peer square wave, scaled up in rate; parked low when not sourcing
    always @(posedge i_ref_clk) begin
        if (!i_sync_run) begin
            cnt <= 0;
            o_sync <= 1'b0;
        end else if (cnt == SYNC_HALF - 1) begin
            cnt <= 0;
            o_sync <= ~o_sync;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// >>> tb/ampc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the amplifier protection and switching control
module ampc_top_bench;
    localparam int DLY = 20;
    localparam int DIV = 8;
    logic        i_ref_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        host_pd_n = 1'b1;
    logic        host_sil = 1'b0;
    logic        loop_en = 1'b0;
    logic        short_det = 1'b0;
    logic        over_temp = 1'b0;
    logic        therm_clear = 1'b0;
    logic        bias_ok = 1'b0;
    logic        role = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic        ps = 1'b0;
    logic        pa = 1'b0;
    wire logic   pd_n, sil, peer_sync, sync_out, sync_oe, alarm, out_en, low_pwr, tick, irq, sync_wire;
    wire logic [31:0] rdata;
    int          n_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n_sync = 0;
    int          n_tick = 0;
    int          n_alarm = 0;
    int          base;
    int          base2;
    logic [31:0] d;
    logic [5:0]  rows [0:5];

    // 200 MHz clock
    always #2.5 i_ref_clk = ~i_ref_clk;

    // Sync pin level: the amplifier drives it in master role, the peer otherwise
    assign sync_wire = sync_oe ? sync_out : peer_sync;

    ampc_host_model PEER (.i_ref_clk(i_ref_clk), .i_host_pd_n(host_pd_n), .i_host_silence(host_sil),
        .i_loop_en(loop_en), .i_alarm(alarm), .i_sync_run(~role), .o_power_down_n(pd_n),
        .o_output_silence(sil), .o_sync(peer_sync));

    ampc_top #(.START_DLY_CYC(DLY), .OSC_DIV(DIV)) DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_power_down_n(pd_n), .i_output_silence(sil), .i_short_det(short_det), .i_over_temp(over_temp),
        .i_therm_clear(therm_clear), .i_bias_ok(bias_ok), .i_clock_role_select(role),
        .i_sync_in(sync_wire), .o_sync_out(sync_out), .o_sync_oe(sync_oe), .o_short_alarm_out(alarm),
        .o_out_enable(out_en), .o_low_power(low_pwr), .o_sw_tick(tick), .i_addr(addr), .i_wdata(wdata),
        .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata), .o_irq(irq));

    task automatic give_verdict();
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Edge counters and the hang limit; the limit is well above the planned run
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        ps <= sync_out;
        pa <= alarm;
        n_tick <= n_tick + ((tick === 1'b1) ? 1 : 0);
        n_sync <= n_sync + ((sync_out === 1'b1 && ps === 1'b0) ? 1 : 0);
        n_alarm <= n_alarm + ((alarm === 1'b1 && pa === 1'b0) ? 1 : 0);
        if (cycles == 6000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Edge counts may slip by one because of phase at the window ends
    task automatic near(input int got, input int exp);
        check(32'(got >= exp - 1 && got <= exp + 1), 32'h1);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_ref_clk);
        bus_wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge i_ref_clk);
        bus_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so sample it there
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_ref_clk);
        bus_rd <= 1'b1;
        addr <= a;
        @(posedge i_ref_clk);
        bus_rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    initial begin
        // Row bits: power_down_n, silence, role, then out_en, low_power, sync_oe
        rows = '{6'h2d, 6'h39, 6'h24, 6'h02, 6'h1b, 6'h2d};
        repeat (12) @(posedge i_ref_clk);
        check(32'({out_en, low_pwr, alarm, irq}), 32'h4);
        i_nrst <= 1'b1;
        rd(8'h04, d);
        check(d, 32'h0);
        cyc(40);
        check(32'(out_en), 32'h0);
        @(posedge i_ref_clk);
        bias_ok <= 1'b1;
        cyc(15);
        check(32'(out_en), 32'h0);
        cyc(15);
        check(32'(out_en), 32'h1);
        for (int i = 0; i < 6; i++) begin
            @(posedge i_ref_clk);
            {host_pd_n, host_sil, role} <= rows[i][5:3];
            cyc(40);
            check(32'({out_en, low_pwr, sync_oe}), 32'(rows[i][2:0]));
        end
        base = n_sync;
        base2 = n_tick;
        cyc(160);
        // One switching period spans DIV reference cycles
        near(n_sync - base, 160 / DIV);
        near(n_tick - base2, 160 / DIV);
        @(posedge i_ref_clk);
        role <= 1'b0;
        cyc(40);
        base = n_tick;
        cyc(240);
        near(n_tick - base, 10);
        check(32'({sync_out, sync_oe}), 32'h0);
        @(posedge i_ref_clk);
        role <= 1'b1;
        cyc(40);
        // Short with no loopback: latched until silence is cycled
        @(posedge i_ref_clk);
        short_det <= 1'b1;
        cyc(1);
        check(32'(out_en), 32'h1);
        cyc(3);
        check(32'({out_en, alarm}), 32'h1);
        @(posedge i_ref_clk);
        short_det <= 1'b0;
        cyc(10);
        check(32'({out_en, alarm, irq}), 32'h2);
        rd(8'h00, d);
        check(d & 32'h1, 32'h1);
        wr(8'h04, 32'h1);
        cyc(2);
        check(32'(irq), 32'h1);
        wr(8'h00, 32'h1);
        cyc(2);
        check(32'(irq), 32'h0);
        @(posedge i_ref_clk);
        host_sil <= 1'b1;
        cyc(3);
        @(posedge i_ref_clk);
        host_sil <= 1'b0;
        cyc(10);
        check(32'({out_en, alarm}), 32'h2);
        // Persistent short with the alarm looped to silence keeps cycling
        @(posedge i_ref_clk);
        loop_en <= 1'b1;
        short_det <= 1'b1;
        base = n_alarm;
        cyc(200);
        check(32'(n_alarm - base >= 2), 32'h1);
        @(posedge i_ref_clk);
        short_det <= 1'b0;
        cyc(40);
        check(32'({out_en, alarm}), 32'h2);
        @(posedge i_ref_clk);
        loop_en <= 1'b0;
        // Over-temperature clears only after hysteresis cooling, then restarts
        @(posedge i_ref_clk);
        over_temp <= 1'b1;
        cyc(5);
        check(32'(out_en), 32'h0);
        @(posedge i_ref_clk);
        over_temp <= 1'b0;
        cyc(20);
        check(32'(out_en), 32'h0);
        @(posedge i_ref_clk);
        therm_clear <= 1'b1;
        cyc(60);
        check(32'(out_en), 32'h1);
        @(posedge i_ref_clk);
        therm_clear <= 1'b0;
        // State register, unmapped place, and one-cycle read data
        rd(8'h08, d);
        check(d, 32'h7);
        // Short, thermal and start events all left sticky bits
        rd(8'h00, d);
        check(d, 32'h7);
        wr(8'h00, 32'h7);
        rd(8'h00, d);
        check(d, 32'h0);
        wr(8'h0c, 32'hffff_ffff);
        rd(8'h0c, d);
        check(d, 32'h0);
        rd(8'h04, d);
        check(d, 32'h1);
        cyc(1);
        check(rdata, 32'h0);
        // Power down before supply removal
        @(posedge i_ref_clk);
        host_pd_n <= 1'b0;
        cyc(5);
        check(32'({out_en, low_pwr}), 32'h1);
        give_verdict();
    end
endmodule
`default_nettype wire
